// ---- hw/ast_uart.sv ----
// asynchronous serial transceiver core with apb registers
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ast_uart (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_tick,
    input wire logic rx_tick,
    input wire logic cpu_irq_masked,
    input wire logic serial_in_pin,
    output logic serial_out,
    output logic serial_out_oe,
    output logic irq
);
    // apb decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_st = paddr == ast_pkg::status_port_addr;
    wire hit_dt = paddr == ast_pkg::data_port_addr;
    wire hit_c1 = paddr == ast_pkg::control_port_one_addr;
    wire hit_c2 = paddr == ast_pkg::control_port_two_addr;
    wire mapped = hit_st || hit_dt || hit_c1 || hit_c2;
    wire st_acc = acc && hit_st;
    wire dt_wr = wr && hit_dt;
    wire dt_rd = rd && hit_dt;
    wire c2_wr = wr && hit_c2;

    logic [7:0] c1_q, c2_q;
    logic tx_buf_empty_q, tc_q, rx_buf_full_q, or_q, nf_q, fe_q;
    logic tx_armed_q, rx_armed_q;
    logic [8:0] rx_buf_q;
    wire nine = c1_q[ast_pkg::c1_nine_bit];
    wire te = c2_q[ast_pkg::c2_tx_enable];
    wire re = c2_q[ast_pkg::c2_rx_enable];
    wire brk = c2_q[ast_pkg::c2_send_break];
    wire te_new = c2_wr && pwdata[ast_pkg::c2_tx_enable];
    wire te_fall = c2_wr && !pwdata[ast_pkg::c2_tx_enable] && te;
    wire [3:0] nbits = nine ? ast_pkg::bits_nine : ast_pkg::bits_eight;
    wire [3:0] nidle = nine ? ast_pkg::idle_nine : ast_pkg::idle_eight;

    // transmitter
    ast_pkg::ast_tx_t tx_q, tx_d;
    logic [3:0] tos_q;
    logic [3:0] tcnt_q;
    logic [8:0] tsh_q;
    logic [8:0] thold_q;
    logic thfull_q, pre_pend_q;
    wire tbit = tx_tick && tos_q == ast_pkg::os_last;
    wire tx_busy = tx_q != ast_pkg::ast_tx_off && tx_q != ast_pkg::ast_tx_idle;
    wire [8:0] wdata = {c1_q[ast_pkg::c1_tx_ninth_bit] && nine, pwdata[7:0]};
    wire direct_load = dt_wr && tx_q == ast_pkg::ast_tx_idle && !brk;
    wire char_end = tbit && tx_q == ast_pkg::ast_tx_stop;
    wire take_hold = thfull_q && !pre_pend_q && !brk && tx_q == ast_pkg::ast_tx_idle;
    wire txdone_ev = char_end && !thfull_q;
    // repeated breaks stay in one state, so the bit count must restart per break
    wire brk_wrap = tbit && tx_q == ast_pkg::ast_tx_brk && tcnt_q == nbits + 4'h1;
    logic tx_line;

    always_comb
    begin
        tx_d = tx_q;
        case (tx_q)
            ast_pkg::ast_tx_off: if (te) tx_d = ast_pkg::ast_tx_pre;
            ast_pkg::ast_tx_idle:
                if (brk) tx_d = ast_pkg::ast_tx_brk;
                else if (pre_pend_q) tx_d = ast_pkg::ast_tx_pre;
                else if (direct_load || take_hold) tx_d = ast_pkg::ast_tx_start;
            ast_pkg::ast_tx_pre: if (tbit && tcnt_q == nidle - 4'h1) tx_d = ast_pkg::ast_tx_idle;
            ast_pkg::ast_tx_start: if (tbit) tx_d = ast_pkg::ast_tx_data;
            ast_pkg::ast_tx_data: if (tbit && tcnt_q == nbits - 4'h1) tx_d = ast_pkg::ast_tx_stop;
            ast_pkg::ast_tx_stop: if (tbit) tx_d = ast_pkg::ast_tx_idle;
            ast_pkg::ast_tx_brk:
                if (tbit && tcnt_q == nbits + 4'h1) tx_d = brk ? ast_pkg::ast_tx_brk : ast_pkg::ast_tx_brk_end;
            ast_pkg::ast_tx_brk_end: if (tbit) tx_d = ast_pkg::ast_tx_idle;
            default: tx_d = ast_pkg::ast_tx_off;
        endcase
        if (!te && !tx_busy)
            tx_d = ast_pkg::ast_tx_off;
    end

    always_comb
    begin
        case (tx_q)
            ast_pkg::ast_tx_start: tx_line = 1'b0;
            ast_pkg::ast_tx_data: tx_line = tsh_q[0];
            ast_pkg::ast_tx_brk: tx_line = 1'b0;
            default: tx_line = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_q <= ast_pkg::ast_tx_off;
            tos_q <= 4'h0;
            tcnt_q <= 4'h0;
            tsh_q <= 9'h000;
            thold_q <= 9'h000;
            thfull_q <= 1'b0;
            pre_pend_q <= 1'b0;
        end
        else
        begin
            tx_q <= tx_d;
            // bit phase restarts whenever the state changes, so each bit is full length
            if (tx_d != tx_q)
                tos_q <= 4'h0;
            else if (tx_tick)
                tos_q <= tos_q + 4'h1;
            if (tx_d != tx_q || brk_wrap)
                tcnt_q <= 4'h0;
            else if (tbit)
                tcnt_q <= tcnt_q + 4'h1;
            if (direct_load)
                tsh_q <= wdata;
            else if (take_hold)
                tsh_q <= thold_q;
            else if (tbit && tx_q == ast_pkg::ast_tx_data)
                tsh_q <= {1'b0, tsh_q[8:1]};
            if (c2_wr && (te_new != te))
                thfull_q <= 1'b0;
            else if (dt_wr && !direct_load)
            begin
                thold_q <= wdata;
                thfull_q <= 1'b1;
            end
            else if (take_hold)
                thfull_q <= 1'b0;
            // preamble follows the current word when enable is re-raised mid-transfer
            if (c2_wr && te_new && !te && tx_busy)
                pre_pend_q <= 1'b1;
            else if (te_fall)
                pre_pend_q <= 1'b0;
            else if (tx_q == ast_pkg::ast_tx_idle)
                pre_pend_q <= 1'b0;
        end
    end

    // receiver: input synchroniser first
    logic rx_s1_q, rx_s2_q;
    ast_pkg::ast_rx_t rx_q;
    logic [3:0] ros_q;
    logic [3:0] rcnt_q;
    logic [8:0] rsh_q;
    logic [2:0] smp_q;
    logic rnoise_q;
    localparam logic [3:0] os_m1 = ast_pkg::os_mid - 4'h1;
    localparam logic [3:0] os_p1 = ast_pkg::os_mid + 4'h1;
    wire rsamp = rx_tick && (ros_q == os_m1 || ros_q == ast_pkg::os_mid || ros_q == os_p1);
    wire rbit_end = rx_tick && ros_q == ast_pkg::os_last;
    wire [2:0] smp_all = {smp_q[1:0], rx_s2_q};
    wire vote = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
    wire disagree = !(smp_q == 3'b000 || smp_q == 3'b111);
    wire rx_char = rbit_end && rx_q == ast_pkg::ast_rx_stop;
    wire [8:0] rword = nine ? rsh_q : {1'b0, rsh_q[8:1]};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_q <= ast_pkg::ast_rx_hunt;
            ros_q <= 4'h0;
            rcnt_q <= 4'h0;
            rsh_q <= 9'h000;
            smp_q <= 3'h0;
            rnoise_q <= 1'b0;
        end
        else
        begin
            rx_s1_q <= serial_in_pin;
            rx_s2_q <= rx_s1_q;
            if (rsamp)
                smp_q <= smp_all;
            if (!re)
                rx_q <= ast_pkg::ast_rx_hunt;
            else
                case (rx_q)
                    ast_pkg::ast_rx_hunt:
                        if (!rx_s2_q)
                        begin
                            rx_q <= ast_pkg::ast_rx_start;
                            ros_q <= 4'h0;
                            rnoise_q <= 1'b0;
                        end
                    ast_pkg::ast_rx_start:
                        if (rx_tick)
                        begin
                            ros_q <= ros_q + 4'h1;
                            if (rbit_end)
                            begin
                                rnoise_q <= disagree;
                                rcnt_q <= 4'h0;
                                // a start that votes high was a glitch
                                rx_q <= vote ? ast_pkg::ast_rx_hunt : ast_pkg::ast_rx_data;
                            end
                        end
                    ast_pkg::ast_rx_data:
                        if (rx_tick)
                        begin
                            ros_q <= ros_q + 4'h1;
                            if (rbit_end)
                            begin
                                rsh_q <= {vote, rsh_q[8:1]};
                                rnoise_q <= rnoise_q | disagree;
                                rcnt_q <= rcnt_q + 4'h1;
                                if (rcnt_q == nbits - 4'h1)
                                    rx_q <= ast_pkg::ast_rx_stop;
                            end
                        end
                    ast_pkg::ast_rx_stop:
                        if (rx_tick)
                        begin
                            ros_q <= ros_q + 4'h1;
                            if (rbit_end)
                                rx_q <= ast_pkg::ast_rx_hunt;
                        end
                    default: rx_q <= ast_pkg::ast_rx_hunt;
                endcase
        end
    end

    // flags and registers; hardware set wins over the software clear sequence
    wire tx_clr = tx_armed_q && dt_wr;
    wire rx_clr = rx_armed_q && dt_rd;
    wire tx_buf_empty_set = direct_load || take_hold || (tx_q == ast_pkg::ast_tx_idle && !thfull_q && te);
    wire rx_store = rx_char && !rx_buf_full_q;
    wire ovr_ev = rx_char && rx_buf_full_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            c1_q <= ast_pkg::ctrl_rst;
            c2_q <= ast_pkg::ctrl_rst;
            tx_buf_empty_q <= ast_pkg::status_rst[ast_pkg::st_tx_buf_empty];
            tc_q <= ast_pkg::status_rst[ast_pkg::st_tx_done_flag];
            rx_buf_full_q <= 1'b0;
            or_q <= 1'b0;
            nf_q <= 1'b0;
            fe_q <= 1'b0;
            tx_armed_q <= 1'b0;
            rx_armed_q <= 1'b0;
            rx_buf_q <= 9'h000;
        end
        else
        begin
            if (wr && hit_c1)
                c1_q <= {c1_q[7], pwdata[6:0]};
            else if (rx_store && nine)
                c1_q[ast_pkg::c1_rx_ninth_bit] <= rword[8];
            if (c2_wr)
                c2_q <= pwdata[7:0];
            if (st_acc)
                tx_armed_q <= 1'b1;
            else if (dt_wr)
                tx_armed_q <= 1'b0;
            if (st_acc)
                rx_armed_q <= 1'b1;
            else if (dt_rd)
                rx_armed_q <= 1'b0;
            if (tx_buf_empty_set)
                tx_buf_empty_q <= 1'b1;
            else if (tx_clr || dt_wr)
                tx_buf_empty_q <= 1'b0;
            if (txdone_ev)
                tc_q <= 1'b1;
            else if (tx_clr)
                tc_q <= 1'b0;
            if (rx_store)
            begin
                rx_buf_q <= rword;
                rx_buf_full_q <= 1'b1;
                nf_q <= rnoise_q;
                fe_q <= !vote;
            end
            else if (rx_clr)
            begin
                rx_buf_full_q <= 1'b0;
                nf_q <= 1'b0;
                fe_q <= 1'b0;
            end
            if (ovr_ev)
                or_q <= 1'b1;
            else if (rx_clr)
                or_q <= 1'b0;
        end
    end

    wire [7:0] st_val = {tx_buf_empty_q, tc_q, rx_buf_full_q, 1'b0, or_q, nf_q, fe_q, 1'b0};
    wire [7:0] rd_mux = hit_st ? st_val : hit_dt ? rx_buf_q[7:0] : hit_c1 ? c1_q : hit_c2 ? c2_q : 8'h00;
    wire irq_d = !cpu_irq_masked && ((tx_buf_empty_q && c2_q[ast_pkg::c2_tx_empty_irq_en])
        || (tc_q && c2_q[ast_pkg::c2_tx_done_irq_en])
        || ((rx_buf_full_q || or_q) && c2_q[ast_pkg::c2_rx_full_irq_en]));

    // outputs registered; pready high from the first clock after reset, so reads come from a flop loaded at setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            serial_out <= 1'b1;
            serial_out_oe <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            prdata <= {24'h00_0000, rd_mux};
            pready <= 1'b1;
            pslverr <= psel && !penable && !mapped;
            serial_out <= tx_line;
            serial_out_oe <= tx_q != ast_pkg::ast_tx_off;
            irq <= irq_d;
        end
    end
endmodule // ast_uart
`default_nettype wire

// ---- include/ast_pkg.sv ----
// constants for the asynchronous serial transceiver
package ast_pkg;
    // register byte addresses
    localparam logic [7:0] status_port_addr = 8'h00;
    localparam logic [7:0] data_port_addr = 8'h04;
    localparam logic [7:0] control_port_one_addr = 8'h08;
    localparam logic [7:0] control_port_two_addr = 8'h0c;
    // status_port bits
    localparam int st_tx_buf_empty = 7;
    localparam int st_tx_done_flag = 6;
    localparam int st_rx_buf_full = 5;
    localparam int st_overrun = 3;
    localparam int st_noise = 2;
    localparam int st_frame = 1;
    // control_port_one bits
    localparam int c1_rx_ninth_bit = 7;
    localparam int c1_tx_ninth_bit = 6;
    localparam int c1_nine_bit = 4;
    // control_port_two bits
    localparam int c2_tx_empty_irq_en = 7;
    localparam int c2_tx_done_irq_en = 6;
    localparam int c2_rx_full_irq_en = 5;
    localparam int c2_tx_enable = 3;
    localparam int c2_rx_enable = 2;
    localparam int c2_send_break = 0;
    // reset values
    localparam logic [7:0] status_rst = 8'hc0;
    localparam logic [7:0] ctrl_rst = 8'h00;
    // oversampling, data bit counts and preamble lengths
    localparam logic [3:0] os_last = 4'hf;
    localparam logic [3:0] os_mid = 4'h7;
    localparam logic [3:0] bits_eight = 4'h8;
    localparam logic [3:0] bits_nine = 4'h9;
    localparam logic [3:0] idle_eight = 4'ha;
    localparam logic [3:0] idle_nine = 4'hb;
    typedef enum logic [2:0] {ast_tx_off, ast_tx_idle, ast_tx_pre, ast_tx_start, ast_tx_data,
        ast_tx_stop, ast_tx_brk, ast_tx_brk_end} ast_tx_t;
    typedef enum logic [1:0] {ast_rx_hunt, ast_rx_start, ast_rx_data, ast_rx_stop} ast_rx_t;
endpackage

// ---- testbench/ast_peer.sv ----
// far-side serial equipment model
`timescale 1ns/1ps
`default_nettype none
module ast_peer (
    input wire logic pclk,
    input wire logic tx_tick,
    input wire logic rx_tick,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    output logic serial_in_pin
);
    int nb = 8;
    logic [8:0] got[$];
    logic [8:0] w;
    // pulled-up line idles high between frames
    initial serial_in_pin = 1'b1;
    task automatic send(input logic [8:0] d, input int n);
        for (int i = 0; i < n + 2; i++)
        begin
            serial_in_pin <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i - 1];
            repeat (16) @(posedge pclk iff rx_tick);
        end
    endtask
    always
    begin
        @(negedge serial_out iff serial_out_oe);
        repeat (8) @(posedge pclk iff tx_tick);
        w = 9'h000;
        for (int i = 0; i < nb; i++)
        begin
            repeat (16) @(posedge pclk iff tx_tick);
            w[i] = serial_out;
        end
        repeat (16) @(posedge pclk iff tx_tick);
        got.push_back(w);
    end
endmodule // ast_peer
`default_nettype wire

// ---- testbench/ast_props.sv ----
// port checker for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module ast_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_tick,
    input wire logic rx_tick,
    input wire logic cpu_irq_masked,
    input wire logic serial_in_pin,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic irq
);
    logic mapped, c1_wr, c2_wr, te_q, n9_q, brk_q, so_q, fw_q;
    logic [2:0] ie_q;
    logic [7:0] pre_q, off_q;
    logic [8:0] fc_q, stop_mid;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};
    assign c1_wr = psel && penable && pwrite && pready && paddr == ast_pkg::control_port_one_addr;
    assign c2_wr = psel && penable && pwrite && pready && paddr == ast_pkg::control_port_two_addr;
    // mid of the stop bit, in ticks from the start edge
    assign stop_mid = n9_q ? 9'h0a8 : 9'h098;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {te_q, ie_q, brk_q, n9_q} <= 6'h0;
        else if (c2_wr)
            {ie_q, te_q, brk_q} <= {pwdata[7:5], pwdata[3], pwdata[0]};
        else if (c1_wr)
            n9_q <= pwdata[ast_pkg::c1_nine_bit];
    end
    // tick counters saturate so a long idle never wraps into a false window
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {pre_q, off_q} <= 16'hffff;
        else
        begin
            if (c2_wr && pwdata[3] && !te_q && !serial_out_oe)
                pre_q <= 8'h00;
            else if (tx_tick && pre_q != 8'hff)
                pre_q <= pre_q + 8'h01;
            if (te_q)
                off_q <= 8'h00;
            else if (tx_tick && off_q != 8'hff)
                off_q <= off_q + 8'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {so_q, fw_q, fc_q} <= 11'h400;
        else
        begin
            so_q <= serial_out;
            if (!fw_q)
            begin
                fw_q <= so_q && !serial_out && serial_out_oe;
                fc_q <= 9'h000;
            end
            else if (tx_tick)
            begin
                fc_q <= fc_q + 9'h001;
                fw_q <= fc_q != stop_mid + 9'h007;
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("no ready in access phase");
    a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_mapped_clean: assert property (psel && penable && mapped |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("mapped access flagged or wide");
    a_irq_masked: assert property ($past(cpu_irq_masked) |-> !irq)
        else $error("irq while cpu masks");
    a_irq_no_enable: assert property (!$past(|ie_q) |-> !irq)
        else $error("irq with all enables clear");
    a_tx_release: assert property (off_q == 8'hff |-> !serial_out_oe)
        else $error("pin still driven when disabled");
    a_preamble_high: assert property (pre_q < 8'ha0 && serial_out_oe |-> serial_out)
        else $error("line low inside preamble");
    a_low_bit_held: assert property (so_q && !serial_out && serial_out_oe |-> !serial_out [*8])
        else $error("low bit too short");
    a_stop_high: assert property (fw_q && fc_q == stop_mid && !brk_q |-> serial_out)
        else $error("stop bit not high");
    c_frame: cover property (fw_q && fc_q == stop_mid);
    c_irq: cover property (!irq ##1 irq);
    c_refused: cover property (psel && penable && pslverr);
endmodule // ast_props
bind ast_uart ast_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_tick(tx_tick), .rx_tick(rx_tick), .cpu_irq_masked(cpu_irq_masked),
    .serial_in_pin(serial_in_pin), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .irq(irq));
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] st_a = ast_pkg::status_port_addr;
    localparam logic [7:0] dp_a = ast_pkg::data_port_addr;
    localparam logic [7:0] c1_a = ast_pkg::control_port_one_addr;
    localparam logic [7:0] c2_a = ast_pkg::control_port_two_addr;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic tx_tick, rx_tick, cpu_irq_masked, serial_in_pin, serial_out, serial_out_oe, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    ast_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_tick(tx_tick), .rx_tick(rx_tick), .cpu_irq_masked(cpu_irq_masked),
        .serial_in_pin(serial_in_pin), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .irq(irq));
    ast_peer peer (.pclk(pclk), .tx_tick(tx_tick), .rx_tick(rx_tick), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .serial_in_pin(serial_in_pin));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // one tick every two clocks: a bit is 32 clocks
    always @(posedge pclk)
    begin
        tx_tick <= ~tx_tick;
        rx_tick <= tx_tick;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // idle cycle first so back-to-back calls never retoggle psel in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input int b);
        v = 32'h0;
        for (int n = 0; n < 300 && v[b] !== 1'b1; n++)
            xfer(1'b0, st_a, 32'h0, v);
    endtask
    task automatic wait_got(input int n);
        for (int k = 0; k < 3000 && peer.got.size() < n; k++)
            @(posedge pclk);
        repeat (40) @(posedge pclk);
    endtask
    task automatic wrap_up();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, tx_tick, rx_tick, cpu_irq_masked} = 7'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        v = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, st_a, 32'h0, v);
        chk(v, 32'h000000c0);
        xfer(1'b0, c2_a, 32'h0, v);
        chk(v, 32'h0);
        xfer(1'b1, 8'h10, 32'hff, v);
        chk(serr, 1'b1);
        xfer(1'b0, 8'h10, 32'h0, v);
        chk(v, 32'h0);
        $display("test registers done");
        xfer(1'b1, c2_a, 32'h48, v);
        repeat (400) @(posedge pclk);
        xfer(1'b0, st_a, 32'h0, v);
        xfer(1'b1, dp_a, 32'ha5, v);
        xfer(1'b0, st_a, 32'h0, v);
        chk(v[7], 1'b1);
        xfer(1'b1, dp_a, 32'h3c, v);
        xfer(1'b0, st_a, 32'h0, v);
        chk(v[7:6], 2'b00);
        chk(irq, 1'b0);
        wait_got(2);
        chk(peer.got[0], 9'h0a5);
        chk(peer.got[1], 9'h03c);
        xfer(1'b0, st_a, 32'h0, v);
        chk(v[7:6], 2'b11);
        chk(irq, 1'b1);
        cpu_irq_masked <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        xfer(1'b1, dp_a, 32'h11, v);
        xfer(1'b1, dp_a, 32'h22, v);
        xfer(1'b1, c2_a, 32'h40, v);
        xfer(1'b1, c2_a, 32'h48, v);
        repeat (1100) @(posedge pclk);
        chk(peer.got.size(), 32'h3);
        chk(peer.got[2], 9'h011);
        xfer(1'b1, c1_a, 32'h50, v);
        peer.nb = 9;
        xfer(1'b0, st_a, 32'h0, v);
        xfer(1'b1, dp_a, 32'h81, v);
        wait_got(4);
        chk(peer.got[3], 9'h181);
        $display("test transmit done");
        cpu_irq_masked <= 1'b0;
        xfer(1'b1, c1_a, 32'h0, v);
        xfer(1'b1, c2_a, 32'h24, v);
        peer.send(9'h05a, 8);
        poll(ast_pkg::st_rx_buf_full);
        chk(irq, 1'b1);
        xfer(1'b0, dp_a, 32'h0, v);
        chk(v, 32'h5a);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        peer.send(9'h011, 8);
        peer.send(9'h022, 8);
        repeat (40) @(posedge pclk);
        xfer(1'b0, st_a, 32'h0, v);
        chk({v[5], v[3]}, 2'b11);
        xfer(1'b0, dp_a, 32'h0, v);
        chk(v, 32'h11);
        xfer(1'b1, c1_a, 32'h10, v);
        peer.send(9'h1c3, 9);
        poll(ast_pkg::st_rx_buf_full);
        xfer(1'b0, c1_a, 32'h0, v);
        chk(v[7], 1'b1);
        xfer(1'b0, dp_a, 32'h0, v);
        chk(v, 32'hc3);
        $display("test receive done");
        xfer(1'b1, c1_a, 32'h0, v);
        peer.nb = 8;
        xfer(1'b1, c2_a, 32'h09, v);
        repeat (1000) @(posedge pclk);
        chk(serial_out, 1'b0);
        xfer(1'b1, c2_a, 32'h08, v);
        repeat (800) @(posedge pclk);
        chk(serial_out, 1'b1);
        chk(peer.got.size(), 32'h5);
        chk(peer.got[4], 9'h000);
        $display("test break done");
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
